//--- design/tal_pkg.sv
// package: constants and types of the thermal alarm register set
package tal_pkg;
  // register selector codes
  localparam logic [1:0] PTR_AMBIENT = 2'h0;
  localparam logic [1:0] PTR_SETUP = 2'h1;
  localparam logic [1:0] PTR_RELEASE = 2'h2;
  localparam logic [1:0] PTR_TRIP = 2'h3;
  // fixed upper nibble of the serial device address
  localparam logic [3:0] ADDR_FIXED = 4'h9;
  // temperature words: 9 meaningful bits, 7 padding bits below
  localparam int TEMP_W = 9;
  localparam logic [6:0] TEMP_PAD = 7'h00;
  localparam logic [8:0] TRIP_RESET = 9'h0fa;
  localparam logic [8:0] RELEASE_RESET = 9'h0f0;
  // bits in one serial byte
  localparam logic [3:0] BIT_COUNT = 4'h8;
  // fault queue run lengths for codes 00, 01, 10, 11
  localparam logic [2:0] RUN_Q0 = 3'h1;
  localparam logic [2:0] RUN_Q1 = 3'h2;
  localparam logic [2:0] RUN_Q2 = 3'h4;
  localparam logic [2:0] RUN_Q3 = 3'h6;

  typedef struct packed {
    logic [2:0] reserved;
    logic [1:0] queue;
    logic polarity;
    logic style;
    logic shutdown;
  } tal_setup_s;

  localparam tal_setup_s SETUP_RESET = tal_setup_s'(8'h00);

  // control bundle sent from the link domain to the core
  typedef struct packed {
    tal_setup_s setup;
    logic [8:0] trip;
    logic [8:0] rel_lim;
  } tal_ctrl_s;

  typedef enum logic [8:0] {
    LS_IDLE = 9'h001,
    LS_ADDR = 9'h002,
    LS_ADDR_ACK = 9'h004,
    LS_PTR = 9'h008,
    LS_PTR_ACK = 9'h010,
    LS_WDATA = 9'h020,
    LS_WDATA_ACK = 9'h040,
    LS_RDATA = 9'h080,
    LS_RDATA_ACK = 9'h100
  } tal_link_e;
endpackage

//--- design/tal_register_set.sv
// module: register set, serial slave and alarm logic of the temperature monitor
`timescale 1ns/1ps

module tal_register_set
  import tal_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic CLK_LINK,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic [2:0] ADDR_SEL,
  input wire logic MEAS_VALID,
  input wire logic [TEMP_W-1:0] MEAS_TEMP,
  output logic CONV_RUN,
  output logic ALARM_OUT
);

  // system domain state, declared first because the link-side crossings read it
  logic creq_meta_ff, creq_ff, creq_old_ff;
  logic rd_meta_ff, rd_ff, rd_old_ff, host_read;
  tal_ctrl_s ctrl_sys_ff;
  logic [8:0] amb_ff, amb_bus_ff;
  logic amb_pend_ff, amb_req_ff, aack_meta_ff, aack_ff;
  logic accept, hot, cold, run_ok, shut_old_ff, shut_rise, arm_hot_ff, alarm_act_ff;
  logic [1:0] last_cat_ff;
  logic [2:0] run_ff, nxt_run, need;
  logic conv_run_ff, alarm_pin_ff;

  // link domain state
  logic [1:0] rst_sync_ff;
  logic rst_link;
  logic scl_meta_ff, scl_ff, scl_old_ff;
  logic sda_meta_ff, sda_ff, sda_old_ff;
  logic [2:0] addr_meta_ff, addr_ff;
  logic scl_rise, scl_fall, start_seen, stop_seen, byte_done, wr_byte;
  tal_link_e state_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_ff, hold_ff, rd_byte;
  logic [15:0] rd_word;
  logic rw_ff, byte_idx_ff, sda_oe_ff, rd_idx, rd_tgl_ff;
  logic [1:0] ptr_ff;
  tal_setup_s setup_link_ff;
  logic [8:0] trip_link_ff, rel_link_ff, amb_link_ff;
  logic dirty_ff, ctrl_req_ff, cack_meta_ff, cack_ff, ctrl_send;
  tal_ctrl_s ctrl_bus_ff;
  logic areq_meta_ff, areq_ff, areq_old_ff, amb_new;

  // reset release synchronised to the link clock
  always_ff @(posedge CLK_LINK or posedge RST) begin
    if (RST) begin
      rst_sync_ff <= 2'h3;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b0};
    end
  end
  assign rst_link = rst_sync_ff[1];

  // pin synchronisers plus one history stage for edge detection
  always_ff @(posedge CLK_LINK or posedge rst_link) begin
    if (rst_link) begin
      {scl_meta_ff, scl_ff, scl_old_ff} <= 3'h7;
      {sda_meta_ff, sda_ff, sda_old_ff} <= 3'h7;
      addr_meta_ff <= 3'h0;
      addr_ff <= 3'h0;
    end else begin
      {scl_meta_ff, scl_ff, scl_old_ff} <= {SCL, scl_meta_ff, scl_ff};
      {sda_meta_ff, sda_ff, sda_old_ff} <= {SDA_I, sda_meta_ff, sda_ff};
      addr_meta_ff <= ADDR_SEL;
      addr_ff <= addr_meta_ff;
    end
  end

  // bus events
  assign scl_rise = scl_ff & ~scl_old_ff;
  assign scl_fall = ~scl_ff & scl_old_ff;
  assign start_seen = scl_ff & scl_old_ff & sda_old_ff & ~sda_ff;
  assign stop_seen = scl_ff & scl_old_ff & ~sda_old_ff & sda_ff;
  assign byte_done = scl_fall && (bit_cnt_ff == BIT_COUNT);
  assign wr_byte = (state_ff == LS_WDATA) && byte_done && !start_seen && !stop_seen;

  // read data: selected word, then high or low byte
  assign rd_idx = (state_ff == LS_RDATA_ACK) ? ~byte_idx_ff : byte_idx_ff;
  always_comb begin
    case (ptr_ff)
      PTR_TRIP: rd_word = {trip_link_ff, TEMP_PAD};
      PTR_RELEASE: rd_word = {rel_link_ff, TEMP_PAD};
      default: rd_word = {amb_link_ff, TEMP_PAD};
    endcase
    rd_byte = rd_idx ? rd_word[7:0] : rd_word[15:8];
    if (ptr_ff == PTR_SETUP) begin
      rd_byte = setup_link_ff;
    end
  end

  // serial slave engine: bit counting, shifting, acknowledge and data drive
  always_ff @(posedge CLK_LINK or posedge rst_link) begin
    if (rst_link) begin
      state_ff <= LS_IDLE;
      bit_cnt_ff <= 4'h0;
      shift_ff <= 8'h00;
      rw_ff <= 1'b0;
      byte_idx_ff <= 1'b0;
      ptr_ff <= PTR_AMBIENT;
      sda_oe_ff <= 1'b0;
      rd_tgl_ff <= 1'b0;
    end else if (start_seen) begin
      state_ff <= LS_ADDR;
      bit_cnt_ff <= 4'h0;
      byte_idx_ff <= 1'b0;
      sda_oe_ff <= 1'b0;
    end else if (stop_seen) begin
      state_ff <= LS_IDLE;
      sda_oe_ff <= 1'b0;
    end else begin
      if (scl_rise) begin
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end
      case (state_ff)
        LS_ADDR, LS_PTR, LS_WDATA: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_ff};
          end
          if (byte_done) begin
            bit_cnt_ff <= 4'h0;
            sda_oe_ff <= 1'b1; // pull low to acknowledge
            if (state_ff == LS_ADDR) begin
              if (shift_ff[7:1] == {ADDR_FIXED, addr_ff}) begin
                rw_ff <= shift_ff[0];
                state_ff <= LS_ADDR_ACK;
              end else begin
                sda_oe_ff <= 1'b0; // not ours: stay silent
                state_ff <= LS_IDLE;
              end
            end else if (state_ff == LS_PTR) begin
              ptr_ff <= shift_ff[1:0];
              state_ff <= LS_PTR_ACK;
            end else begin
              byte_idx_ff <= ~byte_idx_ff;
              state_ff <= LS_WDATA_ACK;
            end
          end
        end
        LS_ADDR_ACK, LS_PTR_ACK, LS_WDATA_ACK: begin
          if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0;
            if (state_ff == LS_ADDR_ACK && rw_ff) begin
              shift_ff <= rd_byte;
              sda_oe_ff <= ~rd_byte[7]; // open drain: drive only zeros
              rd_tgl_ff <= ~rd_tgl_ff; // tells the core a read began
              state_ff <= LS_RDATA;
            end else if (state_ff == LS_ADDR_ACK) begin
              state_ff <= LS_PTR;
            end else begin
              state_ff <= LS_WDATA;
            end
          end
        end
        LS_RDATA: begin
          if (byte_done) begin
            bit_cnt_ff <= 4'h0;
            sda_oe_ff <= 1'b0; // release for the master's acknowledge
            state_ff <= LS_RDATA_ACK;
          end else if (scl_fall) begin
            shift_ff <= {shift_ff[6:0], 1'b0};
            sda_oe_ff <= ~shift_ff[6];
          end
        end
        LS_RDATA_ACK: begin
          if (scl_rise) begin
            shift_ff <= {shift_ff[6:0], sda_ff};
          end
          if (scl_fall) begin
            bit_cnt_ff <= 4'h0;
            if (!shift_ff[0]) begin
              byte_idx_ff <= ~byte_idx_ff;
              shift_ff <= rd_byte;
              sda_oe_ff <= ~rd_byte[7];
              state_ff <= LS_RDATA;
            end else begin
              state_ff <= LS_IDLE; // master declined more data
            end
          end
        end
        LS_IDLE: begin
          sda_oe_ff <= 1'b0;
        end
        default: begin
          state_ff <= LS_IDLE;
          sda_oe_ff <= 1'b0;
        end
      endcase
    end
  end
  assign SDA_O = 1'b0;
  assign SDA_OE = sda_oe_ff;

  // host-written registers; 16-bit words commit on their low byte
  always_ff @(posedge CLK_LINK or posedge rst_link) begin
    if (rst_link) begin
      setup_link_ff <= SETUP_RESET;
      trip_link_ff <= TRIP_RESET;
      rel_link_ff <= RELEASE_RESET;
      hold_ff <= 8'h00;
      dirty_ff <= 1'b0;
    end else begin
      if (ctrl_send) begin
        dirty_ff <= 1'b0;
      end
      if (wr_byte) begin
        if (ptr_ff == PTR_SETUP) begin
          setup_link_ff <= tal_setup_s'({3'h0, shift_ff[4:0]});
          dirty_ff <= 1'b1;
        end else if (!byte_idx_ff) begin
          hold_ff <= shift_ff;
        end else if (ptr_ff == PTR_TRIP) begin
          trip_link_ff <= {hold_ff, shift_ff[7]};
          dirty_ff <= 1'b1;
        end else if (ptr_ff == PTR_RELEASE) begin
          rel_link_ff <= {hold_ff, shift_ff[7]};
          dirty_ff <= 1'b1;
        end
      end
    end
  end

  // control bundle to the core: toggle request, held until acknowledged
  assign ctrl_send = dirty_ff && (ctrl_req_ff == cack_ff);
  always_ff @(posedge CLK_LINK or posedge rst_link) begin
    if (rst_link) begin
      ctrl_req_ff <= 1'b0;
      ctrl_bus_ff <= '{SETUP_RESET, TRIP_RESET, RELEASE_RESET};
    end else if (ctrl_send) begin
      ctrl_req_ff <= ~ctrl_req_ff;
      ctrl_bus_ff <= '{setup_link_ff, trip_link_ff, rel_link_ff};
    end
  end

  // ambient word from the core; changes only through this crossing
  assign amb_new = areq_ff ^ areq_old_ff;
  always_ff @(posedge CLK_LINK or posedge rst_link) begin
    if (rst_link) begin
      {areq_meta_ff, areq_ff, areq_old_ff} <= 3'h0;
      {cack_meta_ff, cack_ff} <= 2'h0;
      amb_link_ff <= 9'h000;
    end else begin
      {areq_meta_ff, areq_ff, areq_old_ff} <= {amb_req_ff, areq_meta_ff, areq_ff};
      {cack_meta_ff, cack_ff} <= {creq_old_ff, cack_meta_ff};
      if (amb_new) begin
        amb_link_ff <= amb_bus_ff;
      end
    end
  end

  // system domain: control capture and read-event detection from the link domain
  assign host_read = rd_ff ^ rd_old_ff;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      {creq_meta_ff, creq_ff, creq_old_ff} <= 3'h0;
      {rd_meta_ff, rd_ff, rd_old_ff} <= 3'h0;
      ctrl_sys_ff <= '{SETUP_RESET, TRIP_RESET, RELEASE_RESET};
    end else begin
      {creq_meta_ff, creq_ff, creq_old_ff} <= {ctrl_req_ff, creq_meta_ff, creq_ff};
      {rd_meta_ff, rd_ff, rd_old_ff} <= {rd_tgl_ff, rd_meta_ff, rd_ff};
      if (creq_ff ^ creq_old_ff) begin
        ctrl_sys_ff <= ctrl_bus_ff; // bundle is stable while request is open
      end
    end
  end

  // ambient reading and its transfer toward the link
  assign accept = MEAS_VALID && !ctrl_sys_ff.setup.shutdown;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      amb_ff <= 9'h000;
      amb_bus_ff <= 9'h000;
      amb_pend_ff <= 1'b0;
      amb_req_ff <= 1'b0;
      {aack_meta_ff, aack_ff} <= 2'h0;
    end else begin
      {aack_meta_ff, aack_ff} <= {areq_old_ff, aack_meta_ff};
      if (amb_pend_ff && (amb_req_ff == aack_ff)) begin
        amb_bus_ff <= amb_ff;
        amb_req_ff <= ~amb_req_ff;
        amb_pend_ff <= 1'b0;
      end
      if (accept) begin
        amb_ff <= MEAS_TEMP;
        amb_pend_ff <= 1'b1;
      end
    end
  end

  // fault queue: signed compare and run of equal results
  assign hot = $signed(MEAS_TEMP) > $signed(ctrl_sys_ff.trip);
  assign cold = $signed(MEAS_TEMP) < $signed(ctrl_sys_ff.rel_lim);
  always_comb begin
    case (ctrl_sys_ff.setup.queue)
      2'h1: need = RUN_Q1;
      2'h2: need = RUN_Q2;
      2'h3: need = RUN_Q3;
      default: need = RUN_Q0;
    endcase
    if ({hot, cold} != last_cat_ff) begin
      nxt_run = 3'h1;
    end else if (run_ff == RUN_Q3) begin
      nxt_run = run_ff;
    end else begin
      nxt_run = run_ff + 3'h1;
    end
  end
  assign run_ok = accept && (hot || cold) && (nxt_run >= need);
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      run_ff <= 3'h0;
      last_cat_ff <= 2'h0;
    end else if (accept) begin
      run_ff <= nxt_run;
      last_cat_ff <= {hot, cold};
    end
  end

  // alarm state in comparator or interrupt style
  assign shut_rise = ctrl_sys_ff.setup.shutdown && !shut_old_ff;
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      shut_old_ff <= 1'b0;
      arm_hot_ff <= 1'b1;
      alarm_act_ff <= 1'b0;
    end else begin
      shut_old_ff <= ctrl_sys_ff.setup.shutdown;
      if (shut_rise && ctrl_sys_ff.setup.style) begin
        alarm_act_ff <= 1'b0;
      end else if (!ctrl_sys_ff.setup.style) begin
        if (run_ok && hot) begin
          alarm_act_ff <= 1'b1;
        end else if (run_ok && cold) begin
          alarm_act_ff <= 1'b0;
        end
      end else begin
        if (host_read) begin
          alarm_act_ff <= 1'b0;
        end
        if (run_ok && (hot == arm_hot_ff)) begin
          alarm_act_ff <= 1'b1; // an event beats a same-cycle clear
          arm_hot_ff <= ~arm_hot_ff;
        end
      end
    end
  end

  // output pins from flops
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      conv_run_ff <= ~SETUP_RESET.shutdown;
      alarm_pin_ff <= ~SETUP_RESET.polarity;
    end else begin
      conv_run_ff <= ~ctrl_sys_ff.setup.shutdown;
      alarm_pin_ff <= alarm_act_ff ~^ ctrl_sys_ff.setup.polarity;
    end
  end
  assign CONV_RUN = conv_run_ff;
  assign ALARM_OUT = alarm_pin_ff;

  // checks
  a_ambient_load: assert property (@(posedge CLK_SYS) disable iff (RST)
    accept |=> amb_ff == $past(MEAS_TEMP)) else $error("ambient not loaded");
  a_shutdown_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    ctrl_sys_ff.setup.shutdown |=> $stable(amb_ff)) else $error("ambient moved in shutdown");
  a_conv_stop: assert property (@(posedge CLK_SYS) disable iff (RST)
    ctrl_sys_ff.setup.shutdown |=> !CONV_RUN) else $error("converting in shutdown");
  a_alarm_polarity: assert property (@(posedge CLK_SYS) disable iff (RST)
    ##1 ALARM_OUT == ($past(alarm_act_ff) ~^ $past(ctrl_sys_ff.setup.polarity)))
    else $error("alarm polarity wrong");
  a_queue_gate: assert property (@(posedge CLK_SYS) disable iff (RST)
    $rose(alarm_act_ff) |-> $past(run_ok)) else $error("alarm without full run");
  a_intr_shutdown: assert property (@(posedge CLK_SYS) disable iff (RST)
    shut_rise && ctrl_sys_ff.setup.style |=> !alarm_act_ff) else $error("alarm kept in shutdown");
  a_comp_trip: assert property (@(posedge CLK_SYS) disable iff (RST)
    !ctrl_sys_ff.setup.style && !shut_rise && run_ok && hot |=> alarm_act_ff ##2 !ALARM_OUT ==
    !ctrl_sys_ff.setup.polarity || ALARM_OUT == ctrl_sys_ff.setup.polarity)
    else $error("comparator did not trip");
  a_reserved_zero: assert property (@(posedge CLK_LINK) disable iff (rst_link)
    setup_link_ff.reserved == 3'h0) else $error("reserved setup bits set");
  a_limit_write: assert property (@(posedge CLK_LINK) disable iff (rst_link)
    wr_byte && byte_idx_ff && ptr_ff == PTR_TRIP |=> trip_link_ff == {$past(hold_ff),
    $past(shift_ff[7])}) else $error("trip limit not written");
  a_ambient_ro: assert property (@(posedge CLK_LINK) disable iff (rst_link)
    !amb_new |=> $stable(amb_link_ff)) else $error("ambient changed by host");
  a_ptr_ack: assert property (@(posedge CLK_LINK) disable iff (rst_link)
    state_ff == LS_PTR && byte_done && !start_seen && !stop_seen |=>
    sda_oe_ff && ptr_ff == $past(shift_ff[1:0])) else $error("pointer byte mishandled");

endmodule // tal_register_set

//--- verification/tal_host_model.sv
// partner model: serial bus master that drives the clock and pulls data low
`timescale 1ns/1ps
module tal_host_model
  import tal_pkg::*;
(
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  // bus idle: both lines released high
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // lines only move after falling core edges; phases last at least 4 core cycles, over 5 link cycles
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_low = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b1;
    tick(8);
    scl = 1'b0;
  endtask

  // stop: data rises while the clock is high
  task automatic stop_cond();
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(8);
    sda_low = 1'b0;
    tick(8);
  endtask

  // one bit: data set mid low phase, sampled late in the high phase
  task automatic bit_slot(input logic b, output logic got);
    tick(4);
    sda_low = ~b;
    tick(4);
    scl = 1'b1;
    tick(8);
    got = sda;
    scl = 1'b0;
  endtask

  // byte out msb first, then the slave's acknowledge slot (1 = no ack)
  task automatic put_byte(input logic [7:0] b, output logic nack);
    logic g;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], g);
    bit_slot(1'b1, nack);
  endtask

  // byte in msb first, then master ack (last = 1 sends no ack)
  task automatic get_byte(input logic last, output logic [7:0] b);
    logic g;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
    bit_slot(last, g);
  endtask

  // write: address, pointer, then n data bytes msb first
  task automatic write_regs(input logic [2:0] sel, input logic [1:0] ptr,
                            input logic [15:0] d, input int n, output logic nack);
    logic k;
    start_cond();
    put_byte({ADDR_FIXED, sel, 1'b0}, nack);
    put_byte({6'h00, ptr}, k);
    nack = nack | k;
    if (n == 2) begin
      put_byte(d[15:8], k);
      nack = nack | k;
    end
    put_byte(d[7:0], k);
    nack = nack | k;
    stop_cond();
  endtask

  // read: set pointer, repeated start, then n bytes msb first
  task automatic read_regs(input logic [2:0] sel, input logic [1:0] ptr,
                           input int n, output logic [15:0] d);
    logic k;
    start_cond();
    put_byte({ADDR_FIXED, sel, 1'b0}, k);
    put_byte({6'h00, ptr}, k);
    start_cond();
    put_byte({ADDR_FIXED, sel, 1'b1}, k);
    get_byte(n == 1, d[15:8]);
    d[7:0] = 8'h00;
    if (n == 2) get_byte(1'b1, d[7:0]);
    stop_cond();
  endtask
endmodule // tal_host_model

//--- verification/tal_register_set_tb_top.sv
// testbench: register access, conversions and alarm behaviour over the serial bus
`timescale 1ns/1ps
module tal_register_set_tb_top;
  import tal_pkg::*;
  logic clk_sys, clk_link, rst, scl, host_low, meas_valid;
  logic [8:0] meas_temp;
  logic sda_o, sda_oe, conv_run, alarm_out, nk;
  logic [8:0] tv [4];
  wire sda_line = (sda_oe ? sda_o : 1'b1) & ~host_low;
  int bad_count, n_checks, run;

  tal_register_set u_dut (.CLK_SYS(clk_sys), .RST(rst), .CLK_LINK(clk_link), .SCL(scl),
    .SDA_I(sda_line), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_SEL(3'h5),
    .MEAS_VALID(meas_valid), .MEAS_TEMP(meas_temp), .CONV_RUN(conv_run),
    .ALARM_OUT(alarm_out));
  tal_host_model u_host (.clk(clk_sys), .sda(sda_line), .scl(scl), .sda_low(host_low));

  // core clock 8 ns, link clock 6 ns with an unrelated phase
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    clk_link = 1'b0;
    #1.3;
    forever #3 clk_link = ~clk_link;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // register write must be acked; settle time lets the values cross to the core
  task automatic wr(input logic [1:0] ptr, input logic [15:0] d, input int n);
    u_host.write_regs(3'h5, ptr, d, n, nk);
    cmp_bit(nk, 1'b0);
    repeat (20) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [1:0] ptr, input int n, input logic [15:0] exp);
    logic [15:0] got;
    u_host.read_regs(3'h5, ptr, n, got);
    cmp_word(got, exp);
  endtask
  // one completed conversion, then time for the alarm to follow
  task automatic meas(input logic [8:0] t);
    @(negedge clk_sys);
    meas_valid = 1'b1;
    meas_temp = t;
    @(negedge clk_sys);
    meas_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (90000) @(posedge clk_sys);
    bad_count++;
    $display("unexpected at %0t got %h exp %h", $time, 1'b0, 1'b1);
    close_out();
  end

  initial begin
    bad_count = 0;
    n_checks = 0;
    rst = 1'b1;
    meas_valid = 1'b0;
    meas_temp = 9'h000;
    tv = '{9'h0fa, 9'h1ff, 9'h192, 9'h000};
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    repeat (10) @(negedge clk_sys);
    // power-up state
    cmp_bit(conv_run, 1'b1);
    cmp_bit(alarm_out, 1'b1);
    rd(PTR_SETUP, 1, 16'h0000);
    rd(PTR_TRIP, 2, {TRIP_RESET, TEMP_PAD});
    rd(PTR_RELEASE, 2, {RELEASE_RESET, TEMP_PAD});
    end_test("reset");
    // limits and setup written and read back, padding bits dropped
    wr(PTR_TRIP, 16'h197f, 2);
    rd(PTR_TRIP, 2, 16'h1900);
    wr(PTR_RELEASE, 16'hc97f, 2);
    rd(PTR_RELEASE, 2, 16'hc900);
    wr(PTR_RELEASE, 16'h1400, 2);
    wr(PTR_SETUP, 16'h001c, 1);
    rd(PTR_SETUP, 1, 16'h1c00);
    wr(PTR_SETUP, 16'h0000, 1);
    end_test("readback");
    // conversions land in the ambient word; host writes there are dropped
    foreach (tv[i]) begin
      meas(tv[i]);
      rd(PTR_AMBIENT, 2, {tv[i], TEMP_PAD});
    end
    wr(PTR_AMBIENT, 16'h5500, 2);
    rd(PTR_AMBIENT, 2, 16'h0000);
    end_test("ambient");
    // fault run lengths; a reading between the limits breaks the run
    for (int q = 0; q < 4; q++) begin
      run = (q == 0) ? 1 : (q == 1) ? 2 : (q == 2) ? 4 : 6;
      wr(PTR_SETUP, {11'h000, q[1:0], 3'h0}, 1);
      repeat (run - 1) meas(9'h040);
      meas(9'h030);
      repeat (run - 1) meas(9'h040);
      cmp_bit(alarm_out, 1'b1);
      meas(9'h040);
      cmp_bit(alarm_out, 1'b0);
      repeat (run - 1) meas(9'h010);
      cmp_bit(alarm_out, 1'b0);
      meas(9'h010);
      cmp_bit(alarm_out, 1'b1);
    end
    end_test("queue");
    // active-high alarm polarity
    wr(PTR_SETUP, 16'h0004, 1);
    cmp_bit(alarm_out, 1'b0);
    meas(9'h040);
    cmp_bit(alarm_out, 1'b1);
    meas(9'h010);
    cmp_bit(alarm_out, 1'b0);
    wr(PTR_SETUP, 16'h0000, 1);
    cmp_bit(alarm_out, 1'b1);
    end_test("polarity");
    // shutdown halts conversions, bus stays usable
    wr(PTR_SETUP, 16'h0001, 1);
    cmp_bit(conv_run, 1'b0);
    meas(9'h055);
    rd(PTR_AMBIENT, 2, {9'h010, TEMP_PAD});
    wr(PTR_TRIP, 16'h1980, 2);
    rd(PTR_TRIP, 2, 16'h1980);
    wr(PTR_TRIP, 16'h1900, 2);
    wr(PTR_SETUP, 16'h0000, 1);
    cmp_bit(conv_run, 1'b1);
    end_test("shutdown");
    // interrupt style alarm raised by a reading above the trip limit
    wr(PTR_SETUP, 16'h0002, 1);
    meas(9'h040);
    cmp_bit(alarm_out, 1'b0);
    // a host read clears the event; the next event is the fall below the release limit
    rd(PTR_SETUP, 1, 16'h0200);
    cmp_bit(alarm_out, 1'b1);
    meas(9'h040);
    cmp_bit(alarm_out, 1'b1);
    meas(9'h010);
    cmp_bit(alarm_out, 1'b0);
    wr(PTR_SETUP, 16'h0003, 1);
    cmp_bit(alarm_out, 1'b1);
    wr(PTR_SETUP, 16'h0000, 1);
    end_test("interrupt");
    // wrong device address is ignored
    u_host.write_regs(3'h2, PTR_TRIP, 16'h0080, 2, nk);
    cmp_bit(nk, 1'b1);
    rd(PTR_TRIP, 2, 16'h1900);
    end_test("address");
    close_out();
  end
endmodule // tal_register_set_tb_top
